/* File: hw/lci_pkg.sv */
package lci_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W  = 3;
	localparam int unsigned DATA_W  = 8;

	// ----------------------------------------------------------------
	// source selection geometry
	// ----------------------------------------------------------------
	localparam int unsigned SEL_W   = 6;
	localparam int unsigned SRC_N   = 64;
	localparam int unsigned DIN_N   = 4;

	// ----------------------------------------------------------------
	// register offsets (word index on the plain port)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_DATA_ONE_SEL   = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_DATA_TWO_SEL   = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_DATA_THREE_SEL = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_DATA_FOUR_SEL  = 3'h3;
	localparam logic [ADDR_W-1:0] OFF_GATE_ZERO_EN   = 3'h4;
	localparam logic [ADDR_W-1:0] OFF_CELL_STATUS    = 3'h5;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned SEL_CODE_LSB   = 0;
	localparam int unsigned SEL_CODE_MSB   = 5;
	localparam int unsigned GZ_FOUR_TRUE   = 7;
	localparam int unsigned GZ_FOUR_INV    = 6;
	localparam int unsigned GZ_THREE_TRUE  = 5;
	localparam int unsigned GZ_THREE_INV   = 4;
	localparam int unsigned GZ_TWO_TRUE    = 3;
	localparam int unsigned GZ_TWO_INV     = 2;
	localparam int unsigned GZ_ONE_TRUE    = 1;
	localparam int unsigned GZ_ONE_INV     = 0;
	localparam int unsigned ST_GATE_ZERO   = 4;

	// ----------------------------------------------------------------
	// reset values of the bus side and synchroniser
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] RD_DATA_RST = 8'h00;
	localparam logic [SRC_N-1:0]  SYNC_RST    = 64'h0000_0000_0000_0000;

endpackage

/* File: hw/lci_sync.sv */
`timescale 1ns/10ps
// two-flop synchroniser for the asynchronous source pins
module lci_sync
(
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	input  wire logic [lci_pkg::SRC_N-1:0] async_in,
	output logic      [lci_pkg::SRC_N-1:0] sync_out
);

	logic [lci_pkg::SRC_N-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= lci_pkg::SYNC_RST;
			sync_out <= lci_pkg::SYNC_RST;
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

/* File: hw/lci_src_mux.sv */
`timescale 1ns/10ps
// one-of-sixty-four source picker for a single data input
module lci_src_mux
(
	input  wire logic [lci_pkg::SRC_N-1:0] sources,
	input  wire logic [lci_pkg::SEL_W-1:0] code,
	output wire logic                      picked
);

	// codes cover all sources, so no code is illegal
	assign picked = sources[code];

endmodule

/* File: hw/lci_top.sv */
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
module lci_top
(
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	input  wire logic [lci_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [lci_pkg::DATA_W-1:0] reg_wr_data,
	input  wire logic                       reg_wr_stb,
	input  wire logic                       reg_rd_stb,
	output logic      [lci_pkg::DATA_W-1:0] reg_rd_data,
	input  wire logic [lci_pkg::SRC_N-1:0]  source_pins,
	output logic                            selected_input_first,
	output logic                            selected_input_second,
	output logic                            selected_input_third,
	output logic                            selected_input_fourth,
	output logic                            gate_zero_out
);

	// ----------------------------------------------------------------
	// address decode helper
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input logic [lci_pkg::ADDR_W-1:0] addr,
		input logic [lci_pkg::ADDR_W-1:0] off);
		addr_hit = (addr == off);
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [lci_pkg::SEL_W-1:0]  sel_reg [lci_pkg::DIN_N];
	logic [lci_pkg::DATA_W-1:0] gate_en_reg;
	logic [lci_pkg::SRC_N-1:0]  src_sync;
	logic [lci_pkg::DIN_N-1:0]  din_pick;
	logic [lci_pkg::DATA_W-1:0] rd_data_next;
	logic [lci_pkg::DATA_W-1:0] sel_read [lci_pkg::DIN_N];
	logic [lci_pkg::DIN_N-1:0]  sel_wr_hit;
	logic [lci_pkg::DATA_W-1:0] status_word;
	logic [lci_pkg::DATA_W-1:0] gate_terms;
	logic                       gate_en_wr_hit;
	logic                       gate_zero_next;
	logic                       sel_rd_any;
	logic [lci_pkg::DATA_W-1:0] sel_rd_word;

	// ----------------------------------------------------------------
	// source pins cross into the clock domain
	// ----------------------------------------------------------------
	lci_sync u_sync
	(
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (source_pins),
		.sync_out (src_sync)
	);

	// ----------------------------------------------------------------
	// select registers and source pickers
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < lci_pkg::DIN_N; gi++)
		begin : g_din
			// index order follows the offsets, one register per data input
			assign sel_wr_hit[gi] = reg_wr_stb &&
				addr_hit(reg_addr, lci_pkg::OFF_DATA_ONE_SEL + lci_pkg::ADDR_W'(gi));

			// no reset: contents survive every reset but power-up
			always_ff @(posedge sys_clk)
			begin
				if (sel_wr_hit[gi])
					sel_reg[gi] <= reg_wr_data[lci_pkg::SEL_CODE_MSB:lci_pkg::SEL_CODE_LSB];
			end

			// upper two bits are not stored and read back as zero
			assign sel_read[gi] = {2'h0, sel_reg[gi]};

			lci_src_mux u_mux
			(
				.sources (src_sync),
				.code    (sel_reg[gi]),
				.picked  (din_pick[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// gate zero term enables
	// ----------------------------------------------------------------
	assign gate_en_wr_hit = reg_wr_stb && addr_hit(reg_addr, lci_pkg::OFF_GATE_ZERO_EN);

	// same retention behaviour as the select registers
	always_ff @(posedge sys_clk)
	begin
		if (gate_en_wr_hit)
			gate_en_reg <= reg_wr_data;
	end

	// ----------------------------------------------------------------
	// gate zero: each term is masked by its own enable bit
	// ----------------------------------------------------------------
	assign gate_terms[lci_pkg::GZ_FOUR_TRUE]  = gate_en_reg[lci_pkg::GZ_FOUR_TRUE]  &  din_pick[3];
	assign gate_terms[lci_pkg::GZ_FOUR_INV]   = gate_en_reg[lci_pkg::GZ_FOUR_INV]   & ~din_pick[3];
	assign gate_terms[lci_pkg::GZ_THREE_TRUE] = gate_en_reg[lci_pkg::GZ_THREE_TRUE] &  din_pick[2];
	assign gate_terms[lci_pkg::GZ_THREE_INV]  = gate_en_reg[lci_pkg::GZ_THREE_INV]  & ~din_pick[2];
	assign gate_terms[lci_pkg::GZ_TWO_TRUE]   = gate_en_reg[lci_pkg::GZ_TWO_TRUE]   &  din_pick[1];
	assign gate_terms[lci_pkg::GZ_TWO_INV]    = gate_en_reg[lci_pkg::GZ_TWO_INV]    & ~din_pick[1];
	assign gate_terms[lci_pkg::GZ_ONE_TRUE]   = gate_en_reg[lci_pkg::GZ_ONE_TRUE]   &  din_pick[0];
	assign gate_terms[lci_pkg::GZ_ONE_INV]    = gate_en_reg[lci_pkg::GZ_ONE_INV]    & ~din_pick[0];

	// a cleared enable forces its term to zero, so the OR never sees it
	assign gate_zero_next = |gate_terms;

	// ----------------------------------------------------------------
	// picked inputs and gate zero leave through flip-flops
	// ----------------------------------------------------------------
	// outputs reset to zero even though the configuration does not
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			selected_input_first  <= 1'b0;
			selected_input_second <= 1'b0;
			selected_input_third  <= 1'b0;
			selected_input_fourth <= 1'b0;
			gate_zero_out         <= 1'b0;
		end
		else
		begin
			selected_input_first  <= din_pick[0];
			selected_input_second <= din_pick[1];
			selected_input_third  <= din_pick[2];
			selected_input_fourth <= din_pick[3];
			gate_zero_out         <= gate_zero_next;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// status shows the picked inputs and gate zero as registered in the output flops
	assign status_word = {3'h0, gate_zero_out, selected_input_fourth, selected_input_third,
		selected_input_second, selected_input_first};

	// select registers sit on consecutive offsets starting at zero
	assign sel_rd_any  = (reg_addr < lci_pkg::OFF_GATE_ZERO_EN);
	assign sel_rd_word = sel_read[reg_addr[1:0]];

	// unmapped offsets read as zero
	assign rd_data_next = !reg_rd_stb                                      ? lci_pkg::RD_DATA_RST :
		sel_rd_any                                                         ? sel_rd_word :
		addr_hit(reg_addr, lci_pkg::OFF_GATE_ZERO_EN)                      ? gate_en_reg :
		addr_hit(reg_addr, lci_pkg::OFF_CELL_STATUS)                       ? status_word :
		lci_pkg::RD_DATA_RST;

	// data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rd_data <= lci_pkg::RD_DATA_RST;
		else
			reg_rd_data <= rd_data_next;
	end

endmodule

/* File: verification/lci_top_sva.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// checker on the top ports
// ----------------------------------------------------------------
module lci_top_sva
(
	input wire logic                       sys_clk,
	input wire logic                       rst_n,
	input wire logic [lci_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [lci_pkg::DATA_W-1:0] reg_wr_data,
	input wire logic                       reg_wr_stb,
	input wire logic                       reg_rd_stb,
	input wire logic [lci_pkg::DATA_W-1:0] reg_rd_data,
	input wire logic [lci_pkg::SRC_N-1:0]  source_pins,
	input wire logic                       selected_input_first,
	input wire logic                       selected_input_second,
	input wire logic                       selected_input_third,
	input wire logic                       selected_input_fourth,
	input wire logic                       gate_zero_out
);
	logic [7:0] en_s;
	logic [7:0] en_d;
	logic       known = 1'b0;
	logic       known_d = 1'b0;
	logic [1:0] live;
	wire        ok = (live == 2'h2) && known_d;
	wire  [7:0] terms = {selected_input_fourth, ~selected_input_fourth, selected_input_third, ~selected_input_third,
		selected_input_second, ~selected_input_second, selected_input_first, ~selected_input_first};

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// shadow of the gating register, not reset since the real one keeps its value
	// plain always: the shadow flags start from declaration values
	always @(posedge sys_clk)
	begin
		if (reg_wr_stb && (reg_addr == lci_pkg::OFF_GATE_ZERO_EN))
		begin
			en_s  <= reg_wr_data;
			known <= 1'b1;
		end
		en_d    <= en_s;
		known_d <= known;
	end

	// output flops need two edges after release before they reflect the registers
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n) live <= 2'h0;
		else if (live != 2'h2) live <= live + 2'h1;
	end

	a_four_true_term: assert property (ok && en_d[7] && selected_input_fourth |-> gate_zero_out)
		else $error("data four true term missing");
	a_four_inv_term: assert property (ok && en_d[6] && !selected_input_fourth |-> gate_zero_out)
		else $error("data four inverted term missing");
	a_three_terms: assert property (ok && |(en_d[5:4] & terms[5:4]) |-> gate_zero_out)
		else $error("data three term missing");
	a_two_terms: assert property (ok && |(en_d[3:2] & terms[3:2]) |-> gate_zero_out)
		else $error("data two term missing");
	a_one_terms: assert property (ok && |(en_d[1:0] & terms[1:0]) |-> gate_zero_out)
		else $error("data one term missing");
	a_gate_exact_or: assert property (ok |-> gate_zero_out == |(en_d & terms))
		else $error("gate zero differs from the enabled terms");
	a_sel_upper_zero: assert property ($past(reg_rd_stb) && ($past(reg_addr) < 3'h4) |-> reg_rd_data[7:6] == 2'h0)
		else $error("select register upper bits not zero");
	a_gating_readback: assert property (known && $past(reg_rd_stb) && ($past(reg_addr) == 3'h4) |-> reg_rd_data == en_s)
		else $error("gating register readback wrong");
	a_rd_idle_zero: assert property (!$past(reg_rd_stb) |-> reg_rd_data == 8'h00)
		else $error("read data not zero outside the read cycle");
endmodule

/* File: verification/lci_top_tb_top.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// self-checking bench
// ----------------------------------------------------------------
module lci_top_tb_top;
	logic                       sys_clk     = 1'b0;
	logic                       rst_n       = 1'b0;
	logic [lci_pkg::ADDR_W-1:0] reg_addr    = 3'h0;
	logic [lci_pkg::DATA_W-1:0] reg_wr_data = 8'h00;
	logic                       reg_wr_stb  = 1'b0;
	logic                       reg_rd_stb  = 1'b0;
	logic [lci_pkg::DATA_W-1:0] reg_rd_data;
	logic [lci_pkg::SRC_N-1:0]  source_pins = 64'h0;
	logic [3:0]                 sel_in;
	logic                       gate_zero_out;
	logic [5:0]                 codes [4]   = '{6'h05, 6'h14, 6'h2A, 6'h3F};
	logic [7:0]                 v;
	logic [7:0]                 en;
	logic [3:0]                 s;
	int                         n_mismatch  = 0;
	int                         n_tests     = 0;

	always #5 sys_clk = ~sys_clk;

	lci_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data), .source_pins(source_pins),
		.selected_input_first(sel_in[0]), .selected_input_second(sel_in[1]), .selected_input_third(sel_in[2]),
		.selected_input_fourth(sel_in[3]), .gate_zero_out(gate_zero_out));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr_stb  <= 1'b1;
		reg_addr    <= a;
		reg_wr_data <= d;
		@(posedge sys_clk);
		reg_wr_stb  <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_rd_stb <= 1'b1;
		reg_addr   <= a;
		@(posedge sys_clk);
		reg_rd_stb <= 1'b0;
		#1 d = reg_rd_data;
	endtask

	// generous wait covering the sync flops and the output flop
	task automatic settle();
		repeat (6) @(posedge sys_clk);
		#1;
	endtask

	function automatic logic gexp(input logic [7:0] e, input logic [3:0] q);
		return |(e & {q[3], ~q[3], q[2], ~q[2], q[1], ~q[1], q[0], ~q[0]});
	endfunction

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if ((n_mismatch == 0) && (n_tests > 0))
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			wr(3'(i), 8'hFF);
			rd(3'(i), v);
			chk(v, 8'h3F);
			wr(3'(i), {2'h0, codes[i]});
		end
		wr(lci_pkg::OFF_GATE_ZERO_EN, 8'hA5);
		rd(3'h6, v);
		chk(v, 8'h00);
		// mid-run reset must not disturb the configuration
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			rd(3'(i), v);
			chk(v, {2'h0, codes[i]});
		end
		rd(lci_pkg::OFF_GATE_ZERO_EN, v);
		chk(v, 8'hA5);
		$display("test registers done");
		for (int i = 0; i < 4; i++)
		begin
			@(posedge sys_clk);
			source_pins <= 64'h1 << codes[i];
			settle();
			chk({4'h0, sel_in}, 8'h01 << i);
		end
		$display("test select done");
		// four input patterns, so every term is seen both high and low
		for (int p = 0; p < 4; p++)
		begin
			s = (p == 0) ? 4'h0 : ((p == 1) ? 4'h9 : ((p == 2) ? 4'h6 : 4'hF));
			@(posedge sys_clk);
			source_pins <= ({63'h0, s[0]} << codes[0]) | ({63'h0, s[1]} << codes[1]) |
				({63'h0, s[2]} << codes[2]) | ({63'h0, s[3]} << codes[3]);
			for (int b = 0; b < 10; b++)
			begin
				en = (b == 8) ? 8'h00 : ((b == 9) ? 8'hFF : (8'h01 << b));
				wr(lci_pkg::OFF_GATE_ZERO_EN, en);
				settle();
				chk({7'h0, gate_zero_out}, {7'h0, gexp(en, s)});
				rd(lci_pkg::OFF_CELL_STATUS, v);
				chk(v, {3'h0, gexp(en, s), s});
			end
		end
		$display("test gating done");
		print_verdict();
	end

	// hang guard
	initial
	begin
		#200000;
		n_mismatch++;
		print_verdict();
	end
endmodule

bind lci_top lci_top_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
	.reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data), .source_pins(source_pins),
	.selected_input_first(selected_input_first), .selected_input_second(selected_input_second),
	.selected_input_third(selected_input_third), .selected_input_fourth(selected_input_fourth),
	.gate_zero_out(gate_zero_out));
